// file: rtl/uart_sio_defines.svh
`ifndef UART_SIO_DEFINES_SVH
`define UART_SIO_DEFINES_SVH

// ------------------------------------------------------------
// register offsets (12-bit address, one byte each)
// ------------------------------------------------------------
`define ADDR_MODE1      12'hf50
`define ADDR_MODE2      12'hf51
`define ADDR_STATUS     12'hf52
`define ADDR_DATA       12'hf53
`define ADDR_PRESCALE   12'hfbe
`define ADDR_BAUD_CNT   12'hfbf

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define MODE1_RST       8'h00
`define MODE2_RST       8'h00
`define PRESCALE_RST    3'h0
`define BAUD_CNT_RST    8'h00
`define DATA_RST        8'h00

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PSC_EN_BIT      2
`define PSC_SEL_HI      1
`define PSC_SEL_LO      0
`define PSC_PAD         5'h00
`define STAT_PAD        2'h0

// ------------------------------------------------------------
// framing and timing
// ------------------------------------------------------------
`define OVS_MID         2'h1
`define OVS_LAST        2'h3
`define CHAR_MIN_IDX    3'h4
`define CHAR_MAX_IDX    3'h7
`define BAUD_EXPIRE     8'h01

`endif

// file: rtl/uart_sio_pkg.sv
package uart_sio_pkg;

  // mode control register 1 layout, bit 7 down to bit 0
  typedef struct packed {
    logic       msb_first_select;
    logic       parity_enable;
    logic       parity_odd_select;
    logic       two_stop_bits;
    logic [1:0] char_length;
    logic       ext_clock_select;
    logic       sync_mode_select;
  } mode1_t;

  // mode control register 2 layout, bit 7 down to bit 0
  typedef struct packed {
    logic clock_pin_drive;
    logic serial_out_pin_enable;
    logic rx_error_clear;
    logic receive_enable;
    logic transmit_enable;
    logic rx_irq_en;
    logic tx_done_irq_en;
    logic tx_empty_irq_en;
  } mode2_t;

  // frame sequencer states
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} frame_st_t;

  // one received character with its error marks
  typedef struct packed {
    logic [7:0] data;
    logic       perr;
    logic       ferr;
  } rx_word_t;

endpackage

// file: rtl/uart_sio_baud.sv
`include "uart_sio_defines.svh"

// prescaler plus reloadable 8-bit down-counter
module uart_sio_baud
  import uart_sio_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       src_tick,
  input  wire logic [1:0] presc_sel,
  input  wire logic [7:0] reload,
  input  wire logic       load,
  input  wire logic       run,
  output logic            baud_clock
);

  logic [2:0] pre_cnt_r;   // prescaler phase
  logic [7:0] cnt_r;       // down-counter
  logic [2:0] pre_mask;    // phase bits that must be all ones
  logic       pre_tick;    // prescaled input pulse
  logic       expire;      // counter reached its end

  // ------------------------------------------------------------
  // prescaler: divide by 1, 2, 4 or 8
  // ------------------------------------------------------------
  assign pre_mask = 3'((4'h1 << presc_sel) - 4'h1);
  assign pre_tick = src_tick && ((pre_cnt_r & pre_mask) == pre_mask);
  assign expire   = run && pre_tick && (cnt_r == `BAUD_EXPIRE);

  // prescaler phase counter
  always_ff @(posedge clk) begin
    if (!rst_b || load) begin
      pre_cnt_r <= 3'h0;
    end else if (src_tick) begin
      pre_cnt_r <= pre_cnt_r + 3'h1;
    end
  end

  // ------------------------------------------------------------
  // down-counter: zero acts as 256
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r      <= `BAUD_CNT_RST;
      baud_clock <= 1'b0;
    end else begin
      baud_clock <= expire;
      if (load) begin
        cnt_r <= reload;
      end else if (expire) begin
        cnt_r <= reload;
      end else if (run && pre_tick) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

endmodule

// file: rtl/uart_sio_rx.sv
`include "uart_sio_defines.svh"

// receive sequencer for both frame modes
module uart_sio_rx
  import uart_sio_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_b,
  input  wire logic   enable,
  input  mode1_t      cfg,
  input  wire logic   os_tick,
  input  wire logic   sio_rise,
  input  wire logic   sin,
  output logic        done,
  output rx_word_t    word
);

  frame_st_t  st_r;      // sequencer state
  logic [1:0] ph_r;      // quarter-bit phase
  logic [2:0] idx_r;     // data bit index
  logic [7:0] buf_r;     // assembled character
  logic [7:0] buf_nxt;   // character with current bit
  logic       perr_r;    // parity mismatch seen
  logic [2:0] last;      // index of last data bit
  logic [2:0] pos;       // bit position for this index
  logic       smp;       // sample point

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  assign last = `CHAR_MIN_IDX + {1'b0, cfg.char_length};
  assign pos  = cfg.msb_first_select ? last - idx_r : idx_r;
  assign smp  = cfg.sync_mode_select ? sio_rise
              : (os_tick && ph_r == `OVS_LAST);

  // place the sampled bit
  always_comb begin
    buf_nxt      = buf_r;
    buf_nxt[pos] = sin;
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= S_IDLE;
      ph_r <= 2'h0;
      idx_r <= 3'h0;
      buf_r <= 8'h00;
      perr_r <= 1'b0;
      done <= 1'b0;
      word <= '0;
    end else begin
      done <= 1'b0;
      if (os_tick) ph_r <= ph_r + 2'h1;
      if (!enable) begin
        st_r <= S_IDLE;
      end else begin
        case (st_r)
          S_IDLE: begin
            idx_r <= 3'h0;
            buf_r <= 8'h00;
            perr_r <= 1'b0;
            ph_r <= 2'h0;
            if (cfg.sync_mode_select) st_r <= S_DATA;
            else if (os_tick && !sin) st_r <= S_START;
          end
          S_START: if (os_tick && ph_r == `OVS_MID) begin
            ph_r <= 2'h0;
            st_r <= sin ? S_IDLE : S_DATA;                 // glitch reject
          end
          S_DATA: if (smp) begin
            buf_r <= buf_nxt;
            idx_r <= idx_r + 3'h1;
            if (idx_r == last) begin
              if (cfg.sync_mode_select) begin
                st_r <= S_IDLE;
                done <= 1'b1;
                word <= '{data: buf_nxt, perr: 1'b0, ferr: 1'b0};
              end else begin
                st_r <= cfg.parity_enable ? S_PAR : S_STOP;
              end
            end
          end
          S_PAR: if (smp) begin
            perr_r <= sin ^ (^buf_r) ^ cfg.parity_odd_select;
            st_r <= S_STOP;
          end
          S_STOP: if (smp) begin
            st_r <= S_IDLE;
            done <= 1'b1;
            word <= '{data: buf_r, perr: perr_r, ferr: !sin};
          end
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end

endmodule

// file: rtl/uart_sio.sv
// The strobed register port was left to the implementer.
`include "uart_sio_defines.svh"

// How it works
// - mode bit picks UART or clocked serial
// - clock select: baud generator or clock pin
// - clock pin drive and output pin enable
// - receive enable stops or runs reception
// - transmit enable stops or runs transmission
// - optional parity, even or odd
// - char length codes give 5 to 8 bits
// - one or two stop bits
// - error clear write 0 clears errors
// - direction bit picks LSB or MSB first
// - data read clears full; first read arms
// - data write clears empty, starts sending
// - interrupt enables gate each request
// - baud enable write 1 reloads and runs
// - prescaler divides by 1, 2, 4, 8
// - prescaler upper bits read zero
// - UART bit is four shift clocks
// - baud input: prescaler tick or machine clock
// - internal clock out is baud over two
// - frame over full buffer sets overrun
module uart_sio
  import uart_sio_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic [11:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR_EN,
  input  wire logic        RD_EN,
  output logic      [7:0]  RDATA,
  input  wire logic        BRG_SRC_SEL,
  input  wire logic        PRESCALE_TICK,
  input  wire logic        SERIAL_CLOCK_PIN_I,
  output logic             SERIAL_CLOCK_PIN_O,
  output logic             SERIAL_CLOCK_PIN_OE_B,
  input  wire logic        SERIAL_IN_PIN,
  output logic             SERIAL_OUT_PIN,
  output logic             SERIAL_OUT_PIN_OE_B,
  output logic             RX_IRQ,
  output logic             TX_IRQ
);

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  mode1_t     m1_r;           // mode control register 1
  mode2_t     m2_r;           // mode control register 2
  logic [2:0] psc_r;          // baud enable and prescale select
  logic [7:0] reload_r;       // baud reload value
  logic [7:0] tdr_r;          // transmit holding data
  logic [7:0] rdr_r;          // receive holding data
  logic       tdr_full_r;     // holding data waits to be sent
  logic       rx_full_r;      // receive holding data valid
  logic       perr_r;         // parity error flag
  logic       ove_r;          // receive lost flag
  logic       ferr_r;         // framing error flag
  logic       tx_done_r;      // transmission complete flag
  logic       rx_armed_r;     // first data read seen
  logic [7:0] rdata_r;        // read data stage

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic       wr_m1;          // write mode 1
  logic       wr_m2;          // write mode 2
  logic       wr_psc;         // write prescale control
  logic       wr_reload;      // write reload value
  logic       wr_data;        // write transmit data
  logic       rd_data;        // read receive data
  logic       err_clr;        // error clear strobe
  logic       brg_load;       // baud counter reload strobe
  logic [7:0] status;         // status byte
  logic [7:0] rd_mux;         // selected read value
  logic       tx_empty;       // transmit holding empty

  assign wr_m1     = WR_EN && ADDR == `ADDR_MODE1;
  assign wr_m2     = WR_EN && ADDR == `ADDR_MODE2;
  assign wr_psc    = WR_EN && ADDR == `ADDR_PRESCALE;
  assign wr_reload = WR_EN && ADDR == `ADDR_BAUD_CNT;
  assign wr_data   = WR_EN && ADDR == `ADDR_DATA;
  assign rd_data   = RD_EN && ADDR == `ADDR_DATA;
  assign err_clr   = wr_m2 && !WDATA[5];
  assign brg_load  = wr_psc && WDATA[`PSC_EN_BIT];
  assign tx_empty  = !tdr_full_r;
  assign status    = {`STAT_PAD, perr_r, ove_r, ferr_r,
                      rx_full_r, tx_done_r, tx_empty};

  // read selection; unmapped reads give zero
  assign rd_mux =
      (ADDR == `ADDR_MODE1)    ? m1_r :
      (ADDR == `ADDR_MODE2)    ? m2_r :
      (ADDR == `ADDR_STATUS)   ? status :
      (ADDR == `ADDR_DATA)     ? rdr_r :
      (ADDR == `ADDR_PRESCALE) ? {`PSC_PAD, psc_r} :
      (ADDR == `ADDR_BAUD_CNT) ? reload_r : 8'h00;

  // ------------------------------------------------------------
  // clock selection and baud generator
  // ------------------------------------------------------------
  logic baud_clock;           // generator output pulse
  logic brg_src;              // generator input pulse
  logic pin_prev_r;           // clock pin last sample
  logic ext_rise;             // clock pin rising edge
  logic ext_fall;             // clock pin falling edge
  logic sclk_r;               // internal serial clock level
  logic sclk_run;             // internal clock may toggle
  logic os_tick;              // UART quarter-bit pulse
  logic sio_rise;             // clocked mode sample event
  logic sio_fall;             // clocked mode shift event
  logic int_clk;              // clocked mode on internal clock

  assign brg_src  = BRG_SRC_SEL ? PRESCALE_TICK : 1'b1;
  assign ext_rise = SERIAL_CLOCK_PIN_I && !pin_prev_r;
  assign ext_fall = !SERIAL_CLOCK_PIN_I && pin_prev_r;
  assign os_tick  = m1_r.ext_clock_select ? ext_rise
                                          : baud_clock;
  assign int_clk  = !m1_r.ext_clock_select;
  assign sio_rise = int_clk ? (baud_clock && sclk_run && !sclk_r)
                            : ext_rise;
  assign sio_fall = int_clk ? (baud_clock && sclk_run && sclk_r)
                            : ext_fall;

  uart_sio_baud u_baud (
    .clk        (CLK),
    .rst_b      (RST_B),
    .src_tick   (brg_src),
    .presc_sel  (psc_r[`PSC_SEL_HI:`PSC_SEL_LO]),
    .reload     (reload_r),
    .load       (brg_load),
    .run        (psc_r[`PSC_EN_BIT]),
    .baud_clock (baud_clock)
  );

  // clock pin sampling and internal clock divide by two
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      pin_prev_r <= 1'b1;
      sclk_r     <= 1'b1;
    end else begin
      pin_prev_r <= SERIAL_CLOCK_PIN_I;
      if (baud_clock && sclk_run) sclk_r <= !sclk_r;
    end
  end

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  frame_st_t  tx_st_r;        // sequencer state
  logic [1:0] tx_ph_r;        // quarter-bit phase
  logic [2:0] tx_idx_r;       // data bit or stop bit index
  logic [7:0] tx_sh_r;        // character being sent
  logic       sout_r;         // serial output level
  logic       sout_nxt;       // next serial output level
  logic       tx_start;       // frame start this cycle
  logic       tx_step;        // UART bit boundary
  logic       tx_fin;         // frame ends this cycle
  logic [2:0] tx_last;        // index of last data bit
  logic [2:0] tx_pos;         // bit position for index
  logic [7:0] tx_mask;        // valid data bits

  assign tx_last  = `CHAR_MIN_IDX + {1'b0, m1_r.char_length};
  assign tx_pos   = m1_r.msb_first_select ? tx_last - tx_idx_r
                                          : tx_idx_r;
  assign tx_mask  = 8'hff >> (`CHAR_MAX_IDX - tx_last);
  assign tx_step  = os_tick && tx_ph_r == `OVS_LAST;
  assign sclk_run = m1_r.sync_mode_select && m2_r.transmit_enable &&
                    (tx_st_r == S_DATA || tdr_full_r);
  assign tx_start = m2_r.transmit_enable && tdr_full_r &&
                    tx_st_r == S_IDLE &&
                    (m1_r.sync_mode_select ? sio_fall : os_tick);
  assign tx_fin   = m2_r.transmit_enable && (m1_r.sync_mode_select
      ? (tx_st_r == S_DATA && sio_rise && tx_idx_r == tx_last)
      : (tx_st_r == S_STOP && tx_step &&
         !(m1_r.two_stop_bits && tx_idx_r == 3'h0)));

  // output level for the current state
  always_comb begin
    case (tx_st_r)
      S_START: sout_nxt = 1'b0;
      S_DATA:  sout_nxt = tx_sh_r[tx_pos];
      S_PAR:   sout_nxt = (^tx_sh_r) ^ m1_r.parity_odd_select;
      default: sout_nxt = 1'b1;
    endcase
  end

  // transmit sequencer
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      tx_st_r  <= S_IDLE;
      tx_ph_r  <= 2'h0;
      tx_idx_r <= 3'h0;
      tx_sh_r  <= `DATA_RST;
      sout_r   <= 1'b1;
    end else begin
      sout_r <= sout_nxt;
      if (os_tick) tx_ph_r <= tx_ph_r + 2'h1;
      if (!m2_r.transmit_enable) begin
        tx_st_r <= S_IDLE;
      end else if (tx_start) begin
        tx_sh_r  <= tdr_r & tx_mask;
        tx_idx_r <= 3'h0;
        tx_ph_r  <= 2'h0;
        tx_st_r  <= m1_r.sync_mode_select ? S_DATA : S_START;
      end else if (tx_fin) begin
        tx_st_r <= S_IDLE;
      end else if (m1_r.sync_mode_select) begin
        if (tx_st_r == S_DATA && sio_fall) tx_idx_r <= tx_idx_r + 3'h1;
      end else if (tx_step) begin
        case (tx_st_r)
          S_START: tx_st_r <= S_DATA;
          S_DATA: begin
            tx_idx_r <= tx_idx_r + 3'h1;
            if (tx_idx_r == tx_last) begin
              tx_idx_r <= 3'h0;
              tx_st_r  <= m1_r.parity_enable ? S_PAR : S_STOP;
            end
          end
          S_PAR:   tx_st_r <= S_STOP;
          S_STOP:  tx_idx_r <= tx_idx_r + 3'h1;
          default: tx_st_r <= S_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------
  logic     rx_done;          // character complete pulse
  rx_word_t rx_word;          // received character
  logic     rx_en;            // receiver may run

  assign rx_en = m2_r.receive_enable && rx_armed_r;

  uart_sio_rx u_rx (
    .clk      (CLK),
    .rst_b    (RST_B),
    .enable   (rx_en),
    .cfg      (m1_r),
    .os_tick  (os_tick),
    .sio_rise (sio_rise),
    .sin      (SERIAL_IN_PIN),
    .done     (rx_done),
    .word     (rx_word)
  );

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      m1_r     <= `MODE1_RST;
      m2_r     <= `MODE2_RST;
      psc_r    <= `PRESCALE_RST;
      reload_r <= `BAUD_CNT_RST;
      tdr_r    <= `DATA_RST;
    end else begin
      if (wr_m1) m1_r <= WDATA;
      if (wr_m2) m2_r <= WDATA;
      if (wr_psc) psc_r <= WDATA[`PSC_EN_BIT:`PSC_SEL_LO];
      if (wr_reload) reload_r <= WDATA;
      if (wr_data) tdr_r <= WDATA;
    end
  end

  // ------------------------------------------------------------
  // status flags: hardware set wins over clear
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      tdr_full_r <= 1'b0;
      tx_done_r  <= 1'b0;
      rx_full_r  <= 1'b0;
      rx_armed_r <= 1'b0;
      perr_r     <= 1'b0;
      ove_r      <= 1'b0;
      ferr_r     <= 1'b0;
      rdr_r      <= `DATA_RST;
    end else begin
      // holding register full until moved into the shifter
      if (wr_data) tdr_full_r <= 1'b1;
      else if (tx_start) tdr_full_r <= 1'b0;
      // completion flag
      if (tx_fin && !tdr_full_r) tx_done_r <= 1'b1;
      else if (wr_data) tx_done_r <= 1'b0;
      // first data read arms the receiver
      if (rd_data) rx_armed_r <= 1'b1;
      // receive buffer and errors
      if (rx_done && rx_full_r) begin
        ove_r <= 1'b1;
      end else if (rx_done) begin
        rdr_r     <= rx_word.data;
        rx_full_r <= 1'b1;
        perr_r    <= rx_word.perr | (perr_r & !err_clr);
        ferr_r    <= rx_word.ferr | (ferr_r & !err_clr);
      end else begin
        if (rd_data) rx_full_r <= 1'b0;
        if (err_clr) begin
          perr_r <= 1'b0;
          ferr_r <= 1'b0;
        end
      end
      if (err_clr && !(rx_done && rx_full_r)) ove_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // read port and outputs
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rdata_r <= 8'h00;
      RX_IRQ  <= 1'b0;
      TX_IRQ  <= 1'b0;
    end else begin
      rdata_r <= RD_EN ? rd_mux : 8'h00;
      RX_IRQ  <= m2_r.rx_irq_en &&
                 (rx_full_r || perr_r || ove_r || ferr_r);
      TX_IRQ  <= (m2_r.tx_done_irq_en && tx_done_r) ||
                 (m2_r.tx_empty_irq_en && tx_empty);
    end
  end

  assign RDATA                 = rdata_r;
  assign SERIAL_CLOCK_PIN_O    = sclk_r;
  assign SERIAL_CLOCK_PIN_OE_B = !m2_r.clock_pin_drive;
  assign SERIAL_OUT_PIN        = sout_r;
  assign SERIAL_OUT_PIN_OE_B   = !m2_r.serial_out_pin_enable;

endmodule

// file: verification/uart_sio_properties.sv
module uart_sio_properties (
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic [11:0] ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR_EN,
  input wire logic        RD_EN,
  input wire logic [7:0]  RDATA,
  input wire logic        SERIAL_OUT_PIN,
  input wire logic        SERIAL_OUT_PIN_OE_B,
  input wire logic        SERIAL_CLOCK_PIN_OE_B,
  input wire logic        RX_IRQ,
  input wire logic        TX_IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // bus decodes and checks
  // ----
  wire logic st = RD_EN && ADDR == 12'hf52; // status read
  wire logic rx = RD_EN && ADDR == 12'hf53; // rx data read
  wire logic ps = RD_EN && ADDR == 12'hfbe; // prescale read
  wire logic m2 = WR_EN && ADDR == 12'hf51; // mode2 write
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  AST_PAD: assert property ($past(ps) |-> RDATA[7:3] == 5'h00)
    else $error("pad bits set");
  AST_DO_OE: assert property ($past(m2) |->
    SERIAL_OUT_PIN_OE_B == !$past(WDATA[6])) else $error("out oe");
  AST_CK_OE: assert property ($past(m2) |->
    SERIAL_CLOCK_PIN_OE_B == !$past(WDATA[7])) else $error("clk oe");
  AST_RX_MASK: assert property (m2 && !WDATA[2] |=> ##1 !RX_IRQ)
    else $error("rx irq unmasked");
  AST_TX_MASK: assert property (m2 && WDATA[1:0] == 2'h0
    |=> ##1 !TX_IRQ) else $error("tx irq unmasked");
  AST_RST: assert property (disable iff (1'b0) !RST_B |=>
    RDATA == 8'h00 && SERIAL_OUT_PIN && SERIAL_OUT_PIN_OE_B && !RX_IRQ
    && !TX_IRQ) else $error("reset state");
  AST_RD_CLR: assert property ($past(rx, 3) && $past(st) |-> !RDATA[2])
    else $error("full kept");
  AST_ERR_CLR: assert property ($past(m2, 3) && !$past(WDATA[5], 3)
    && $past(st) |-> RDATA[5:3] == 3'h0) else $error("errors kept");
endmodule
bind uart_sio uart_sio_properties uart_sio_properties_inst (.CLK(CLK),
  .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
  .RDATA(RDATA), .SERIAL_OUT_PIN(SERIAL_OUT_PIN),
  .SERIAL_OUT_PIN_OE_B(SERIAL_OUT_PIN_OE_B),
  .SERIAL_CLOCK_PIN_OE_B(SERIAL_CLOCK_PIN_OE_B), .RX_IRQ(RX_IRQ),
  .TX_IRQ(TX_IRQ));

// file: verification/uart_sio_far_end.sv
module uart_sio_far_end (
  input  wire logic CLK,
  input  wire logic clock_from_dut,
  input  wire logic line_from_dut,
  output logic      line_to_dut
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // remote uart, line idles high
  // ----
  localparam int BIT = 16; // four shift ticks of four clocks
  initial line_to_dut = 1'b1;
  // start bit, then nb wire bits
  task automatic send(input logic [11:0] b, input int nb);
    for (int i = -1; i < nb; i++) begin
      line_to_dut <= (i < 0) ? 1'b0 : b[i];
      repeat (BIT) @(posedge CLK);
    end
    line_to_dut <= 1'b1;
  endtask
  // samples each bit in its middle
  task automatic get(input int nb, output logic [11:0] b);
    b = '1;
    @(negedge line_from_dut);
    repeat (BIT / 2) @(posedge CLK);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT) @(posedge CLK);
      b[i] = line_from_dut;
    end
  endtask
  // clocked mode: new bit after each fall, sample on each rise
  task automatic xfer(input logic [7:0] o, output logic [11:0] b);
    b = '0;
    for (int i = 0; i < 8; i++) begin
      @(negedge clock_from_dut);
      line_to_dut <= o[i];
      @(posedge clock_from_dut);
      b[i] = line_from_dut;
    end
    line_to_dut <= 1'b1;
  endtask
endmodule

// file: verification/test_uart_sio.sv
module test_uart_sio
  import uart_sio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // stimulus, model and checks
  // ----
  logic        CLK = 1'b0, RST_B = 1'b0, WR_EN = 1'b0, RD_EN = 1'b0;
  logic [11:0] ADDR = 12'h000;
  logic [7:0]  WDATA = 8'h00;
  logic [7:0]  RDATA;
  logic        so, si, sck, rx_irq, tx_irq;
  logic [31:0] seed = 32'h2c6918e1; // xorshift state
  int          mismatches = 0, samples_checked = 0;
  localparam logic [11:0] reg_a [7] = '{12'hf50, 12'hf51, 12'hf52, 12'hf53,
    12'hfbe, 12'hfbf, 12'h123};
  localparam logic [7:0] reg_e [7] = '{0, 0, 8'h01, 0, 0, 0, 0};
  uart_sio uart_sio_inst (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR),
    .WDATA(WDATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA),
    .BRG_SRC_SEL(1'b0), .PRESCALE_TICK(1'b0), .SERIAL_CLOCK_PIN_I(1'b0),
    .SERIAL_CLOCK_PIN_O(sck), .SERIAL_CLOCK_PIN_OE_B(), .SERIAL_IN_PIN(si),
    .SERIAL_OUT_PIN(so), .SERIAL_OUT_PIN_OE_B(), .RX_IRQ(rx_irq),
    .TX_IRQ(tx_irq));
  uart_sio_far_end uart_sio_far_end_inst (.CLK(CLK), .line_from_dut(so),
    .clock_from_dut(sck), .line_to_dut(si));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected wire bits after the start bit
  function automatic logic [11:0] bits(input logic [7:0] d, input mode1_t m,
                                       output int nb);
    int n;
    logic [11:0] b;
    n = m.char_length + 5;
    b = '1;
    for (int i = 0; i < n; i++) b[i] = m.msb_first_select ? d[n-1-i] : d[i];
    if (m.parity_enable) b[n] = m.parity_odd_select ^ ^(d & (8'hff >> (8-n)));
    nb = n + 1 + m.parity_enable + m.two_stop_bits;
    return b;
  endfunction
  task automatic chk(input string what, input logic [11:0] e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR_EN <= 1'b1;
    @(posedge CLK);
    WR_EN <= 1'b0;
  endtask
  // read, keep masked bits, compare
  task automatic rdc(input logic [11:0] a, input logic [7:0] mk, e);
    @(posedge CLK);
    ADDR <= a;
    RD_EN <= 1'b1;
    @(posedge CLK);
    RD_EN <= 1'b0;
    #1 chk($sformatf("reg %h", a), e & mk, RDATA & mk);
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    forever #5 CLK = ~CLK;
  end
  // whole run is a few thousand cycles
  initial begin
    repeat (40000) @(posedge CLK);
    mismatches++;
    report_and_stop();
  end
  initial begin
    logic [7:0] d, d2;
    logic [11:0] ex, got, fb;
    mode1_t m;
    int nb;
    repeat (20) @(posedge CLK);
    RST_B <= 1'b1;
    foreach (reg_a[i]) rdc(reg_a[i], 8'hff, reg_e[i]);
    wr(12'hfbf, 8'h04); // while stopped, not below 2
    wr(12'hfbe, 8'hfc);
    rdc(12'hfbe, 8'hff, 8'h04);
    wr(12'hf51, 8'h7d);
    rdc(12'hf53, 8'h00, 8'h00); // receiver already armed by the reset-value reads
    chk("tx_irq", 12'h001, {11'h0, tx_irq});
    wr(12'hf51, 8'h7c);
    for (int k = 0; k < 8; k++) begin
      if (k == 4) begin // same bit time from 2 x 2
        wr(12'hfbe, 8'h00);
        wr(12'hfbf, 8'h02);
        wr(12'hfbe, 8'h05);
      end
      m = mode1_t'(8'(rnd()));
      m.char_length = k[1:0];
      m.msb_first_select = k[2];
      m.ext_clock_select = 1'b0;
      m.sync_mode_select = 1'b0;
      wr(12'hf50, m);
      d = 8'(rnd());
      d2 = 8'(rnd());
      ex = bits(d, m, nb);
      fb = bits(d2, m, nb);
      fork
        wr(12'hf53, d);
        uart_sio_far_end_inst.get(nb, got);
        uart_sio_far_end_inst.send(fb, nb);
      join
      chk("tx_frame", ex, got);
      repeat (16) @(posedge CLK);
      rdc(12'hf52, 8'h07, 8'h07);
      rdc(12'hf53, 8'hff >> (2'd3 - m.char_length), d2);
    end
    m = mode1_t'(8'h4c);
    wr(12'hf50, m);
    fb = bits(d, m, nb);
    fb[8] = ~fb[8];
    fb[9] = 1'b0;
    uart_sio_far_end_inst.send(fb, nb);
    rdc(12'hf52, 8'h3c, 8'h2c);
    fb = bits(d2, m, nb);
    uart_sio_far_end_inst.send(fb, nb);
    rdc(12'hf52, 8'h3c, 8'h3c);
    chk("rx_irq", 12'h001, {11'h0, rx_irq});
    rdc(12'hf53, 8'hff, d);
    rdc(12'hf52, 8'h3c, 8'h38);
    wr(12'hf51, 8'h5c);
    rdc(12'hf52, 8'h3c, 8'h00);
    wr(12'hf51, 8'h78);
    rdc(12'hf51, 8'hff, 8'h78);
    chk("rx_irq", 12'h000, {11'h0, rx_irq});
    wr(12'hf51, 8'hf8);
    wr(12'hf50, 8'h0d); // clocked mode, internal clock
    d = 8'(rnd());
    d2 = 8'(rnd());
    fork
      wr(12'hf53, d);
      uart_sio_far_end_inst.xfer(d2, got);
    join
    chk("sio_tx", {4'h0, d}, got);
    rdc(12'hf53, 8'hff, d2);
    chk("sck", 12'h001, {11'h0, sck});
    report_and_stop();
  end
endmodule
